// [logic/ercam_block.sv]
// Notes on behaviour
// [R01] Per port, input registers on input clock, outputs on output clock; here both sides run on the one clk with clock enables.
// [R02] Each port has own read/write clock enables and clear.
// [R03] All registers cleared by local clear, global clear or reset; the APB control, care and config address registers here clear only on reset.
// [R04] Dual-port memory uses only half A or half B.
// [R05] Single-port: no simultaneous read and write; two memories per block.
// [R06] One single-port memory: 4096x1 up to 128x32, width doubling.
// [R07] CAM compares search word against all words in parallel.
// [R08] Match flag goes high when a stored word equals the search.
// [R09] CAM holds 32 words of 32 bits.
// [R10] Don't-care bits of stored words are ignored in comparisons.
// [R11] Single, multiple and fast multiple match; encoded or line outputs.
// [R12] Unencoded: 16 result lines covering all words.
// [R13] Unencoded: top search bit selects bank, 31 bits compared.
// [R14] Select one reports odd words, zero reports even words.
// [R15] Single-match: write two cycles, search one cycle.
// [R16] Multiple-match: write two cycles, search over two cycles.
// [R17] Outside logic priority-encodes multiple-match lines if needed.
// [R18] Fast multiple-match: one cycle, at most 16 words.
// [R19] Contents preloaded or written; write 2 cycles, 3 with don't-care.
// [R20] Each port's registers bypassable individually.
// [R21] Read-only lookup mode returns preloaded contents.
// [R22] Match flag low when nothing matches after masking.
//
// Added by the designer: the APB register port and the register offsets.
`default_nettype none
module ercam_block (
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic glb_clr, // Global clear of both ports' pipelines and the search state
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire ercam_pkg::ercam_port_s port_a, // Port A requests
  input wire ercam_pkg::ercam_port_s port_b, // Port B requests
  output logic [31:0] dout_a, // Port A read data
  output logic [31:0] dout_b, // Port B read data
  output ercam_pkg::ercam_cam_s cam_out // Search results
);

  function automatic logic [31:0] wmask(logic [2:0] w);
    logic [5:0] n;
    n = 6'h01 << w;
    if (w >= ercam_pkg::WIDTH_MAX) return 32'hFFFF_FFFF;
    return 32'((33'h1 << n) - 33'h1);
  endfunction

  function automatic logic [11:0] bit_idx(logic [11:0] a, logic [2:0] w,
                                          logic split, logic half);
    logic [11:0] s;
    s = 12'(a << w);
    return split ? {half, s[10:0]} : s;
  endfunction

  function automatic logic [4:0] first_hit(logic [31:0] h);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (h[i]) r = 5'(i);
    end
    return r;
  endfunction

  logic [31:0] mem [ercam_pkg::MEM_WORDS];
  logic [31:0] care [ercam_pkg::CAM_WORDS];
  ercam_pkg::ercam_mode_e mode;
  logic [2:0] width;
  logic half_sel;
  logic unenc;
  logic [11:0] byp;
  logic [31:0] care_reg;
  logic [6:0] cfg_addr;

  ercam_pkg::ercam_port_s pin [2];
  logic [31:0] dout [2];
  logic wr_go [2];
  logic rd_go [2];
  logic [11:0] wbit [2];
  logic [11:0] rbit [2];
  logic [31:0] wd [2];
  logic [31:0] rd_val [2];
  logic ewe [2];
  logic ere [2];

  logic split;
  logic sp_mode;
  logic cam_mode;
  assign pin[0] = port_a;
  assign pin[1] = port_b;
  assign dout_a = dout[0];
  assign dout_b = dout[1];
  assign split = (mode == ercam_pkg::MODE_SP2) ||
                 (mode == ercam_pkg::MODE_DP);
  assign sp_mode = (mode == ercam_pkg::MODE_SP1) ||
                   (mode == ercam_pkg::MODE_SP2);
  assign cam_mode = (mode == ercam_pkg::MODE_CAM_SINGLE) ||
                    (mode == ercam_pkg::MODE_CAM_MULTI) ||
                    (mode == ercam_pkg::MODE_CAM_FAST);

  // APB slave
  logic acc;
  logic [31:0] status;
  assign acc = psel && penable && pready;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable && !pready;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      unique case (paddr)
        ercam_pkg::ADDR_CTRL:
          prdata <= {12'h000, byp, unenc, half_sel, width, mode};
        ercam_pkg::ADDR_CARE: prdata <= care_reg;
        ercam_pkg::ADDR_STATUS: prdata <= status;
        ercam_pkg::ADDR_CFG_ADDR: prdata <= {25'h0000000, cfg_addr};
        ercam_pkg::ADDR_CFG_DATA: prdata <= mem[cfg_addr];
        default: pslverr <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= ercam_pkg::ercam_mode_e'(ercam_pkg::CTRL_RESET[2:0]);
      width <= ercam_pkg::CTRL_RESET[5:3];
      half_sel <= ercam_pkg::CTRL_RESET[ercam_pkg::CTRL_HALF_BIT];
      unenc <= ercam_pkg::CTRL_RESET[ercam_pkg::CTRL_UNENC_BIT];
      byp <= ercam_pkg::CTRL_RESET[19:8];
      care_reg <= ercam_pkg::CARE_RESET;
      cfg_addr <= 7'h00;
    end else if (acc && pwrite) begin
      unique case (paddr)
        ercam_pkg::ADDR_CTRL: begin
          mode <= (pwdata[2:0] == 3'h7) ? ercam_pkg::MODE_SP1 :
                  ercam_pkg::ercam_mode_e'(pwdata[2:0]);
          width <= (pwdata[5:3] > ercam_pkg::WIDTH_MAX) ?
                   ercam_pkg::WIDTH_MAX : pwdata[5:3]; // see [R06]
          half_sel <= pwdata[ercam_pkg::CTRL_HALF_BIT];
          unenc <= pwdata[ercam_pkg::CTRL_UNENC_BIT];
          byp <= pwdata[ercam_pkg::CTRL_BYP_LSB +: 12]; // see [R20]
        end
        ercam_pkg::ADDR_CARE: care_reg <= pwdata;
        ercam_pkg::ADDR_CFG_ADDR: cfg_addr <= pwdata[6:0];
        default: ;
      endcase
    end
  end

  // Port pipelines
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [5:0] pb;
    logic qwe;
    logic qre;
    logic [11:0] qwa;
    logic [11:0] qra;
    logic [31:0] qwd;
    logic [31:0] rdq;
    logic clr;
    logic cw;
    logic cr;
    logic [11:0] wa;
    logic [11:0] ra;
    assign pb = byp[6*p +: 6];
    assign clr = pin[p].clr || glb_clr; // see [R02] [R03]

    // Input side: one clock for data, enables and both addresses
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        qwe <= 1'b0;
        qre <= 1'b0;
        qwa <= 12'h000;
        qra <= 12'h000;
        qwd <= 32'h0000_0000;
      end else if (clr) begin // see [R03]
        qwe <= 1'b0;
        qre <= 1'b0;
        qwa <= 12'h000;
        qra <= 12'h000;
        qwd <= 32'h0000_0000;
      end else begin
        qwe <= pin[p].we && pin[p].wce; // see [R01] [R02]
        qre <= pin[p].re && pin[p].rce;
        if (pin[p].wce) begin
          qwa <= pin[p].waddr;
          qwd <= pin[p].wdata;
        end
        if (pin[p].rce) begin
          qra <= pin[p].raddr;
        end
      end
    end

    always_comb begin
      ewe[p] = pb[ercam_pkg::BYP_WE] ? (pin[p].we && pin[p].wce) : qwe;
      ere[p] = pb[ercam_pkg::BYP_RE] ? (pin[p].re && pin[p].rce) : qre;
      wa = pb[ercam_pkg::BYP_WADDR] ? pin[p].waddr : qwa; // see [R20]
      ra = pb[ercam_pkg::BYP_RADDR] ? pin[p].raddr : qra;
      wd[p] = pb[ercam_pkg::BYP_DIN] ? pin[p].wdata : qwd;
      cw = 1'b0;
      cr = 1'b0;
      unique case (mode)
        ercam_pkg::MODE_SP1: begin
          cw = (p == 0);
          cr = (p == 0);
        end
        ercam_pkg::MODE_SP2: begin // see [R05]
          cw = 1'b1;
          cr = 1'b1;
        end
        ercam_pkg::MODE_DP: begin // see [R04]
          cw = (p == 0);
          cr = (p == 1);
        end
        ercam_pkg::MODE_ROM: cr = (p == 0); // see [R21]
        default: ;
      endcase
      wr_go[p] = ewe[p] && cw;
      rd_go[p] = ere[p] && cr && !(sp_mode && ewe[p]); // see [R05]
      wbit[p] = bit_idx(wa, width, split,
                        (mode == ercam_pkg::MODE_SP2) ? 1'(p) : half_sel);
      rbit[p] = bit_idx(ra, width, split,
                        (mode == ercam_pkg::MODE_SP2) ? 1'(p) : half_sel);
      rd_val[p] = (mem[rbit[p][11:5]] >> rbit[p][4:0]) & wmask(width);
    end

    // Output side: separate clock enable, or bypassed
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        rdq <= 32'h0000_0000;
        dout[p] <= 32'h0000_0000;
      end else if (clr) begin
        rdq <= 32'h0000_0000;
        dout[p] <= 32'h0000_0000;
      end else if (pb[ercam_pkg::BYP_DOUT]) begin
        if (rd_go[p]) dout[p] <= rd_val[p]; // see [R20]
      end else begin
        if (rd_go[p]) rdq <= rd_val[p];
        if (pin[p].oce) dout[p] <= rdq; // see [R01]
      end
    end
  end

  // Search logic
  logic [1:0] cam_cnt;
  logic [4:0] cw_addr;
  logic [31:0] cw_data;
  logic [31:0] cw_care;
  logic phase;
  logic [31:0] key_q;
  logic [31:0] key;
  logic [31:0] cmp_mask;
  logic [31:0] hit;
  logic cam_wr_go;
  logic search_go;
  logic single_unenc;
  assign single_unenc = (mode == ercam_pkg::MODE_CAM_SINGLE) && unenc;
  assign cam_wr_go = cam_mode && ewe[0] && (cam_cnt == 2'h0) &&
                     !((mode == ercam_pkg::MODE_CAM_FAST) &&
                       wbit[0][4]); // see [R18]
  assign search_go = cam_mode && ere[0] && (cam_cnt == 2'h0) && !phase;
  assign key = phase ? key_q : wd[0];
  assign cmp_mask = single_unenc ? 32'h7FFF_FFFF : 32'hFFFF_FFFF;

  always_comb begin
    for (int i = 0; i < ercam_pkg::CAM_WORDS; i++) begin
      hit[i] = (((mem[i] ^ key) & care[i] & cmp_mask) == 32'h0000_0000)
               && !((mode == ercam_pkg::MODE_CAM_FAST) &&
                    (i >= ercam_pkg::FAST_WORDS)); // see [R07] [R10] [R18]
    end
  end

  // CAM write address comes from port A write address, one word each
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cam_cnt <= 2'h0;
      cw_addr <= 5'h00;
      cw_data <= 32'h0000_0000;
      cw_care <= ercam_pkg::CARE_RESET;
    end else if (glb_clr || pin[0].clr) begin
      cam_cnt <= 2'h0;
    end else if (cam_wr_go) begin
      cam_cnt <= (care_reg == ercam_pkg::CARE_RESET) ?
                 ercam_pkg::CAM_WR_CYCLES :
                 ercam_pkg::CAM_WR_CYCLES_MASKED; // see [R15] [R16] [R19]
      cw_addr <= wbit[0][4:0];
      cw_data <= wd[0];
      cw_care <= care_reg;
    end else if (cam_cnt != 2'h0) begin
      cam_cnt <= cam_cnt - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (wr_go[p]) begin
        mem[wbit[p][11:5]] <= (mem[wbit[p][11:5]] &
                               ~(wmask(width) << wbit[p][4:0])) |
                              ((wd[p] & wmask(width)) << wbit[p][4:0]);
      end
    end
    if (acc && pwrite && (paddr == ercam_pkg::ADDR_CFG_DATA)) begin
      mem[cfg_addr] <= pwdata; // see [R19] [R21]
      care[cfg_addr[4:0]] <= care_reg;
    end
    if (cam_cnt == 2'h1) begin
      mem[cw_addr] <= cw_data; // see [R09]
      care[cw_addr] <= cw_care;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= 1'b0;
      key_q <= 32'h0000_0000;
      cam_out <= '0;
    end else if (glb_clr || pin[0].clr) begin
      phase <= 1'b0;
      cam_out <= '0;
    end else begin
      cam_out.busy <= cam_wr_go || (cam_cnt > 2'h1);
      phase <= search_go && (mode == ercam_pkg::MODE_CAM_MULTI);
      key_q <= search_go ? wd[0] : key_q;
      cam_out.valid <= search_go || phase; // see [R15] [R16] [R18]
      if (search_go || phase) begin
        cam_out.match <= |hit; // see [R08] [R22]
        cam_out.addr <= first_hit(hit); // see [R11]
        cam_out.bank <= phase;
        unique case (mode)
          ercam_pkg::MODE_CAM_MULTI: // see [R16] [R17]
            cam_out.lines <= phase ? hit[31:16] : hit[15:0];
          ercam_pkg::MODE_CAM_FAST: cam_out.lines <= hit[15:0];
          default: begin
            for (int k = 0; k < ercam_pkg::LINES; k++) begin
              cam_out.lines[k] <= single_unenc ?
                hit[2*k + int'(key[31])] : hit[k]; // see [R12] [R13] [R14]
            end
          end
        endcase
      end
    end
  end

  assign status = {cam_out.lines, 8'h00, cam_out.bank, cam_out.addr,
                   cam_out.match, cam_out.busy};

  // Checks
  sequence s_setup;
    psel && !penable && !pready;
  endsequence
  sequence s_cam_wr_clean;
    cam_wr_go && (care_reg == ercam_pkg::CARE_RESET);
  endsequence
  sequence s_two_busy;
    cam_out.busy [*2] ##1 !cam_out.busy;
  endsequence

  property p_apb_ready;
    @(posedge clk) disable iff (!rst_b) s_setup |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("pready timing");

  property p_cam_write_two;
    @(posedge clk) disable iff (!rst_b || glb_clr || pin[0].clr)
      s_cam_wr_clean |=> s_two_busy;
  endproperty
  a_cam_write_two: assert property (p_cam_write_two) // see [R19]
    else $error("CAM write not two cycles");

  property p_cam_write_three;
    @(posedge clk) disable iff (!rst_b || glb_clr || pin[0].clr)
      cam_wr_go && (care_reg != ercam_pkg::CARE_RESET) |=>
        cam_out.busy [*3] ##1 !cam_out.busy;
  endproperty
  a_cam_write_three: assert property (p_cam_write_three) // see [R19]
    else $error("Masked CAM write not three cycles");

  property p_search_one;
    @(posedge clk) disable iff (!rst_b || glb_clr || pin[0].clr)
      search_go && (mode != ercam_pkg::MODE_CAM_MULTI) |=>
        cam_out.valid ##1 (!cam_out.valid || $past(search_go, 1));
  endproperty
  a_search_one: assert property (p_search_one) // see [R15]
    else $error("Search result not one cycle");

  property p_multi_two;
    @(posedge clk) disable iff (!rst_b || glb_clr || pin[0].clr)
      search_go && (mode == ercam_pkg::MODE_CAM_MULTI) |=>
        (cam_out.valid && !cam_out.bank) ##1
        (cam_out.valid && cam_out.bank);
  endproperty
  a_multi_two: assert property (p_multi_two) // see [R16]
    else $error("Multi-match not two banks");

  property p_no_match;
    @(posedge clk) disable iff (!rst_b)
      cam_out.valid && !cam_out.match |-> cam_out.lines == 16'h0000;
  endproperty
  a_no_match: assert property (p_no_match) // see [R22]
    else $error("Lines set without match");

  property p_fast_line;
    @(posedge clk) disable iff (!rst_b)
      cam_out.valid && cam_out.match && mode == ercam_pkg::MODE_CAM_FAST
      |-> cam_out.lines[cam_out.addr[3:0]] && !cam_out.addr[4];
  endproperty
  a_fast_line: assert property (p_fast_line) // see [R18]
    else $error("Fast match line wrong");

  property p_sp_no_read;
    @(posedge clk) disable iff (!rst_b)
      sp_mode && ewe[0] |-> !rd_go[0];
  endproperty
  a_sp_no_read: assert property (p_sp_no_read) // see [R05]
    else $error("Read during write in single-port");

  property p_rom_no_write;
    @(posedge clk) disable iff (!rst_b)
      mode == ercam_pkg::MODE_ROM |-> !wr_go[0] && !wr_go[1];
  endproperty
  a_rom_no_write: assert property (p_rom_no_write) // see [R21]
    else $error("Write in read-only mode");

  property p_clear;
    @(posedge clk) disable iff (!rst_b)
      port_a.clr |=> dout_a == 32'h0000_0000;
  endproperty
  a_clear: assert property (p_clear) // see [R03]
    else $error("Port A clear ignored");

endmodule // ercam_block
`default_nettype wire

// [logic/ercam_pkg.sv]
`default_nettype none
package ercam_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CARE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CFG_ADDR = 8'h0C;
  localparam logic [7:0] ADDR_CFG_DATA = 8'h10;
  // Control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_WIDTH_LSB = 3;
  localparam int CTRL_HALF_BIT = 6;
  localparam int CTRL_UNENC_BIT = 7;
  localparam int CTRL_BYP_LSB = 8;
  // Bypass bit positions inside a port's six-bit group
  localparam int BYP_DIN = 0;
  localparam int BYP_DOUT = 1;
  localparam int BYP_RADDR = 2;
  localparam int BYP_WADDR = 3;
  localparam int BYP_WE = 4;
  localparam int BYP_RE = 5;
  // Status field positions
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_MATCH_BIT = 1;
  localparam int STAT_ADDR_LSB = 2;
  localparam int STAT_BANK_BIT = 7;
  localparam int STAT_LINES_LSB = 16;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CARE_RESET = 32'hFFFF_FFFF;
  // Array shape and timing counts
  localparam int MEM_WORDS = 128;
  localparam int CAM_WORDS = 32;
  localparam int FAST_WORDS = 16;
  localparam int LINES = 16;
  localparam logic [2:0] WIDTH_MAX = 3'h5;
  localparam logic [1:0] CAM_WR_CYCLES = 2'h2;
  localparam logic [1:0] CAM_WR_CYCLES_MASKED = 2'h3;

  typedef enum logic [2:0] {
    MODE_SP1,
    MODE_SP2,
    MODE_DP,
    MODE_CAM_SINGLE,
    MODE_CAM_MULTI,
    MODE_CAM_FAST,
    MODE_ROM
  } ercam_mode_e;

  typedef struct packed {
    logic we;
    logic re;
    logic wce;
    logic rce;
    logic oce;
    logic clr;
    logic [11:0] waddr;
    logic [11:0] raddr;
    logic [31:0] wdata;
  } ercam_port_s;

  typedef struct packed {
    logic valid;
    logic match;
    logic busy;
    logic bank;
    logic [4:0] addr;
    logic [15:0] lines;
  } ercam_cam_s;
endpackage
`default_nettype wire

// [tb/ercam_user_model.sv]
`default_nettype none
module ercam_user_model (
  input wire logic clk, // System clock
  output var ercam_pkg::ercam_port_s port_a, // Port A requests
  output var ercam_pkg::ercam_port_s port_b // Port B requests
);
  timeunit 1ns;
  timeprecision 1ps;
  ercam_pkg::ercam_port_s idle;
  initial begin
    idle = '0;
    idle.oce = 1'b1;
    port_a = idle;
    port_b = idle;
  end
  // One request held for one cycle: kind 0 write, 1 read, 2 clear
  task automatic op(input bit pb, input int kind, input logic [11:0] adr,
                    input logic [31:0] d);
    ercam_pkg::ercam_port_s p;
    p = idle;
    p.we = (kind == 0);
    p.wce = (kind == 0);
    p.re = (kind == 1);
    p.rce = (kind == 1);
    p.clr = (kind == 2);
    p.waddr = adr;
    p.raddr = adr;
    p.wdata = d;
    @(posedge clk);
    if (pb) port_b <= p;
    else port_a <= p;
    @(posedge clk);
    // Released lines show the inverse, never the old value
    idle.waddr = ~adr;
    idle.raddr = ~adr;
    idle.wdata = ~d;
    if (pb) port_b <= idle;
    else port_a <= idle;
  endtask
  // Lowest hit among one bank of result lines
  function automatic logic [4:0] prio(input logic [15:0] l, input logic bk);
    for (int i = 0; i < 16; i++) begin
      if (l[i]) return {bk, 4'(i)};
    end
    return 5'h1F;
  endfunction
endmodule // ercam_user_model
`default_nettype wire

// [tb/tb_ercam_block.sv]
`default_nettype none
module tb_ercam_block;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, glb_clr, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, dout_a, dout_b, rd;
  ercam_pkg::ercam_port_s port_a, port_b;
  ercam_pkg::ercam_cam_s cam_out, r0, r1;
  int mismatches = 0;
  int num_checks = 0;
  int n;
  ercam_block dut (
    .clk(clk),
    .rst_b(rst_b),
    .glb_clr(glb_clr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .port_a(port_a),
    .port_b(port_b),
    .dout_a(dout_a),
    .dout_b(dout_b),
    .cam_out(cam_out)
  );
  ercam_user_model um (.clk(clk), .port_a(port_a), .port_b(port_b));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ctrl(input logic [31:0] v);
    apb(1'b1, ercam_pkg::ADDR_CTRL, v);
  endtask
  function automatic logic [31:0] res(input ercam_pkg::ercam_cam_s c);
    return {10'h000, c.match, c.addr, c.lines};
  endfunction
  task automatic srch(input logic [31:0] key);
    um.op(1'b0, 1, 12'h000, key);
    do begin
      @(posedge clk);
    end while (cam_out.valid !== 1'b1);
    r0 = cam_out;
    @(posedge clk);
    r1 = cam_out;
  endtask
  task automatic camw(input logic [4:0] w, input logic [31:0] d,
                      input logic [31:0] cyc);
    n = 0;
    um.op(1'b0, 0, {7'h00, w}, d);
    repeat (8) begin
      @(posedge clk);
      if (cam_out.busy === 1'b1) n++;
    end
    chk("busy cycles", 32'(n), cyc);
  endtask
  task automatic rchk(input bit pb, input logic [11:0] a,
                      input logic [31:0] e);
    um.op(pb, 1, a, 32'h0000_0000);
    repeat (6) @(posedge clk);
    chk("read data", pb ? dout_b : dout_a, e);
  endtask
  initial begin
    rst_b = 1'b0;
    glb_clr = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, ercam_pkg::ADDR_CTRL, 32'h0000_0000);
    chk("ctrl reset", rd, ercam_pkg::CTRL_RESET);
    apb(1'b0, ercam_pkg::ADDR_CARE, 32'h0000_0000);
    chk("care reset", rd, ercam_pkg::CARE_RESET);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped err", 32'(er), 32'h0000_0001);
    $display("test reset done");
    for (int i = 0; i < ercam_pkg::CAM_WORDS; i++) begin
      apb(1'b1, ercam_pkg::ADDR_CFG_ADDR, 32'(i));
      apb(1'b1, ercam_pkg::ADDR_CFG_DATA, 32'h0100_0000 + 32'(i));
    end
    apb(1'b0, ercam_pkg::ADDR_CFG_DATA, 32'h0000_0000);
    chk("cfg readback", rd, 32'h0100_001F);
    ctrl(32'h0000_3F03);
    srch(32'h0100_0007);
    chk("preload hit", res(r0), 32'h0027_0080);
    srch(32'h5555_5555);
    chk("no hit", 32'({r0.match, r0.lines}), 32'h0000_0000);
    camw(5'h09, 32'hCAFE_0009, 32'h0000_0002);
    srch(32'hCAFE_0009);
    chk("written hit", res(r0), 32'h0029_0200);
    apb(1'b1, ercam_pkg::ADDR_CARE, 32'hFFFF_FF00);
    camw(5'h14, 32'h7700_0000, 32'h0000_0003);
    apb(1'b1, ercam_pkg::ADDR_CARE, 32'hFFFF_FFFF);
    srch(32'h7700_00AB);
    chk("masked hit", res(r0), 32'h0034_0000);
    ctrl(32'h0000_3F83);
    srch(32'h8100_0005);
    chk("odd bank", res(r0), 32'h0025_0004);
    srch(32'h0100_0004);
    chk("even bank", res(r0), 32'h0024_0004);
    $display("test single match done");
    ctrl(32'h0000_3F04);
    camw(5'h03, 32'h00DD_00DD, 32'h0000_0002);
    camw(5'h19, 32'h00DD_00DD, 32'h0000_0002);
    srch(32'h00DD_00DD);
    chk("multi bank0", res(r0), 32'h0023_0008);
    chk("multi bank1", 32'({r1.valid, r1.bank, r1.lines}),
        32'h0003_0200);
    chk("prio", 32'(um.prio(r1.lines, r1.bank)), 32'h0000_0019);
    apb(1'b0, ercam_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("status", rd, 32'h0200_008E);
    ctrl(32'h0000_3F05);
    srch(32'h00DD_00DD);
    chk("fast hit", res(r0), 32'h0023_0008);
    chk("fast one cycle", 32'(r1.valid), 32'h0000_0000);
    srch(32'h7700_00AB);
    chk("fast upper", 32'(r0.match), 32'h0000_0000);
    $display("test multi match done");
    for (int k = 0; k < 2; k++) begin
      ctrl(k == 0 ? 32'h0000_3F28 : 32'h0000_0028);
      um.op(1'b0, 0, 12'h064, 32'hDEAD_BEEF + 32'(k));
      rchk(1'b0, 12'h064, 32'hDEAD_BEEF + 32'(k));
    end
    ctrl(32'h0000_3F18);
    um.op(1'b0, 0, 12'h005, 32'h1234_56A5);
    rchk(1'b0, 12'h005, 32'h0000_00A5);
    ctrl(32'h0000_3F2E);
    um.op(1'b0, 0, 12'h064, 32'h0000_0000);
    rchk(1'b0, 12'h064, 32'hDEAD_BEF0);
    $display("test memory done");
    ctrl(32'h000F_FF19);
    um.op(1'b1, 0, 12'h009, 32'h0000_005A);
    um.op(1'b0, 0, 12'h009, 32'h0000_0033);
    rchk(1'b1, 12'h009, 32'h0000_005A);
    rchk(1'b0, 12'h009, 32'h0000_0033);
    um.op(1'b0, 2, 12'h000, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk("port clear", dout_a, 32'h0000_0000);
    chk("other port", dout_b, 32'h0000_005A);
    glb_clr <= 1'b1;
    @(posedge clk);
    glb_clr <= 1'b0;
    repeat (2) @(posedge clk);
    chk("global clear", dout_b, 32'h0000_0000);
    // Dual-port: A writes, B reads, both in the upper half
    ctrl(32'h000F_FF5A);
    um.op(1'b0, 0, 12'h009, 32'h0000_0077);
    um.op(1'b1, 0, 12'h009, 32'h0000_0011);
    rchk(1'b1, 12'h009, 32'h0000_0077);
    $display("test split and clear done");
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule // tb_ercam_block
`default_nettype wire
